// ==== ctl_action_unpack.sv ====
`timescale 1ns/1ps
module ctl_action_unpack
	import ctl_pkg::*;
(
	// Raw action words, offset 0 first
	input wire logic [3:0][CTL_ACTION_W-1:0] words_in,
	// Logical action
	output logic [1:0] act_size_out,
	output logic [CTL_ACT_LOG_W-1:0] action_out
);

	// Size follows the type-group code at offset 0; no code gives zeros
	always_comb
	begin
		action_out = '0;
		act_size_out = CTL_ASZ_X1;
		if (words_in[0][0])
		begin
			action_out[68:0] = words_in[0][69:1]; // [R14]
		end
		else if (words_in[0][1])
		begin
			act_size_out = CTL_ASZ_X2;
			action_out[67:0] = words_in[0][69:2]; // [R14]
			action_out[136:68] = words_in[1][69:1];
		end
		else if (words_in[0][2])
		begin
			act_size_out = CTL_ASZ_X4;
			action_out[66:0] = words_in[0][69:3]; // [R14]
			action_out[135:67] = words_in[1][69:1];
			action_out[203:136] = words_in[2][69:2];
			action_out[272:204] = words_in[3][69:1];
		end
	end

endmodule

// ==== ctl_lookup.sv ====
`timescale 1ns/1ps
// Summary of operation
// (R1) One assigned block gives 4096 addresses of entry, action, counter.
// (R2) Entries span 1, 2, 4, 8 or 16 consecutive addresses.
// (R3) Configuring side puts type-group codes in entry low bits.
// (R4) Offset 0 entry code is a one-hot size code, 0b1 up to 0b10000.
// (R5) Odd entry offsets carry one zero type-group bit.
// (R6) Entry offsets 2, 6, 10, 14 carry two zero bits.
// (R7) Entry offsets 4 and 12 carry three zero bits.
// (R8) Entry offset 8 carries four zero bits.
// (R9) Configuring side puts type-group codes in action low bits too.
// (R10) Offset 0 action code is 0b1, 0b10 or 0b100 by size.
// (R11) Action offsets 1 and 3 carry one zero bit.
// (R12) Action offset 2 carries two zero bits.
// (R13) Logical entry bits fill each address above its type-group, low first.
// (R14) Each address gives 70 action bits less its type-group width.
// (R15) Default rule is chosen with the key, used when nothing matches.
// (R16) With no block assigned, never match; always apply the default.
// (R17) First lookup: 114 defaults at 32768 plus 16 times n.
// (R18) Second lookup: 114 defaults at 34592 plus 16 times n.
// (R19) Third lookup: 114 defaults at 36416 plus 16 times n.
// (R20) An n-address rule starts at a multiple of n.
// (R21) Wide rules are written highest address first, lowest last.
// (R22) A match sets the one-bit saturating counter at rule offset 0.
// (R23) Entry addresses beyond a narrower entry are disabled.
// (R24) Type-group bits are matched like key bits.
module ctl_lookup
	import ctl_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic reset_n_in,
	// Allocation
	input wire logic blocks_assigned_in,
	// Configuration writes
	input wire logic cfg_valid_in,
	input wire ctl_cfg_t cfg_in,
	// Key submission
	input wire logic key_valid_in,
	input wire ctl_key_t key_in,
	output logic key_ready_out,
	// Result
	output ctl_res_t res_out
);

	function automatic logic [2:0] ctl_tg_width(input logic [3:0] off,
		input logic [2:0] sz);
		if (off == 4'h0)
			ctl_tg_width = sz + 3'h1; // [R4]
		else if (off[0])
			ctl_tg_width = 3'h1; // [R5]
		else if (off[1])
			ctl_tg_width = 3'h2; // [R6]
		else if (off[2])
			ctl_tg_width = 3'h3; // [R7]
		else
			ctl_tg_width = 3'h4; // [R8]
	endfunction

	// Raw word for one offset: key chunk above the type-group code
	function automatic logic [CTL_ENTRY_W-1:0] ctl_key_word(
		input logic [CTL_KEY_W-1:0] k, input logic [3:0] off,
		input logic [2:0] sz);
		logic [CTL_ENTRY_W-1:0] tg;
		logic [CTL_ENTRY_W-1:0] d;
		tg = (off == 4'h0) ? (36'h1 << sz) : 36'h0;
		d = k[CTL_ENTRY_W-1:0] << ctl_tg_width(off, sz); // [R13]
		ctl_key_word = d | tg; // [R24]
	endfunction

	function automatic logic [15:0] ctl_def_addr(input logic [1:0] sel,
		input logic [6:0] idx);
		logic [15:0] b;
		case (sel)
			2'h0: b = CTL_DEF_BASE_FIRST; // [R17]
			2'h1: b = CTL_DEF_BASE_SECOND; // [R18]
			default: b = CTL_DEF_BASE_THIRD; // [R19]
		endcase
		ctl_def_addr = b + {5'h00, idx, 4'h0};
	endfunction

	// {usable, slot, word}; the three default tables sit back to back
	function automatic logic [11:0] ctl_def_slot(input logic [15:0] a);
		logic [15:0] rel;
		rel = a - CTL_DEF_BASE_FIRST;
		ctl_def_slot = {a >= CTL_DEF_BASE_FIRST && rel[15:13] == 3'h0 &&
			rel[12:4] < CTL_DEF_SLOTS && rel[3:2] == 2'h0, rel[12:4], rel[1:0]};
	endfunction

	// Storage; memory contents are undefined until written, enables and counters reset to zero
	logic [CTL_ENTRY_W-1:0] ent_mem [0:CTL_BLOCK_ADDRS-1];
	logic [CTL_ENTRY_W-1:0] msk_mem [0:CTL_BLOCK_ADDRS-1];
	logic [CTL_ACTION_W-1:0] act_mem [0:CTL_BLOCK_ADDRS-1];
	logic [CTL_ACTION_W-1:0] def_mem [0:CTL_DEF_TOTAL-1][0:CTL_DEF_WORDS-1];
	logic [CTL_BLOCK_ADDRS-1:0] en_q;
	logic [CTL_BLOCK_ADDRS-1:0] cnt_q;
	logic [CTL_DEF_TOTAL-1:0] def_cnt_q;

	ctl_state_t state_q;
	ctl_state_t state_d;
	logic [CTL_ENTRY_W-1:0] scan_word;
	logic [11:0] scan_idx;
	logic word_match;
	logic [12:0] rule_n;
	logic [12:0] next_start;
	logic [11:0] cfg_slot;
	logic [11:0] fetch_slot;
	logic [15:0] def_addr;
	logic [3:0][CTL_ACTION_W-1:0] fetch_words;
	logic [1:0] unp_size;
	logic [CTL_ACT_LOG_W-1:0] unp_action;
	logic [12:0] busy_q;

	assign key_ready_out = state_q.ready;
	assign res_out = state_q.res;

	assign scan_idx = state_q.addr[11:0];
	assign scan_word = ctl_key_word(state_q.key_sh, state_q.off,
		state_q.req.size);
	// Mask bit set means don't care
	assign word_match = state_q.blk && en_q[scan_idx] &&
		(((scan_word ^ ent_mem[scan_idx]) & ~msk_mem[scan_idx]) == 36'h0);
	assign rule_n = 13'h1 << state_q.req.size; // [R2]
	// Aligned rules let a miss skip straight to the next rule start
	assign next_start = state_q.addr - {9'h000, state_q.off} + rule_n; // [R20]
	assign def_addr = ctl_def_addr(state_q.req.lookup, state_q.req.def_idx);
	assign fetch_slot = ctl_def_slot(def_addr);
	assign cfg_slot = ctl_def_slot(cfg_in.addr);

	always_comb
	begin
		for (int k = 0; k < CTL_DEF_WORDS; k++)
		begin
			fetch_words[k] = state_q.found ?
				act_mem[state_q.start + 12'(k)] :
				def_mem[fetch_slot[10:2]][k];
		end
	end

	ctl_action_unpack ctl_action_unpack_i (
		.words_in(fetch_words),
		.act_size_out(unp_size),
		.action_out(unp_action)
	);

	always_comb
	begin
		state_d = state_q;
		state_d.res.valid = 1'h0;
		case (state_q.st)
			CTL_IDLE:
			begin
				if (key_valid_in)
				begin
					state_d.req = key_in;
					if (key_in.size > CTL_SIZE_MAX)
						state_d.req.size = CTL_SIZE_MAX;
					if (key_in.def_idx > CTL_DEF_LAST)
						state_d.req.def_idx = CTL_DEF_LAST;
					state_d.key_sh = key_in.key;
					state_d.addr = 13'h0;
					state_d.off = 4'h0;
					state_d.found = 1'h0;
					state_d.blk = blocks_assigned_in;
					state_d.ready = 1'h0;
					// No block: skip the scan, default applies
					state_d.st = blocks_assigned_in ? CTL_SCAN : CTL_FETCH; // [R16]
				end
			end
			CTL_SCAN:
			begin
				if (word_match && state_q.off == rule_n[3:0] - 4'h1)
				begin
					// Lowest address wins, so stop at first full match
					state_d.found = 1'h1;
					state_d.start = scan_idx - {8'h00, state_q.off};
					state_d.st = CTL_FETCH;
				end
				else if (word_match)
				begin
					state_d.addr = state_q.addr + 13'h1;
					state_d.off = state_q.off + 4'h1;
					state_d.key_sh = state_q.key_sh >> (6'h24 -
						{3'h0, ctl_tg_width(state_q.off, state_q.req.size)}); // [R13]
				end
				else
				begin
					state_d.addr = next_start;
					state_d.off = 4'h0;
					state_d.key_sh = state_q.req.key;
					if (next_start >= CTL_SCAN_END) // [R1]
						state_d.st = CTL_FETCH; // [R15]
				end
			end
			CTL_FETCH:
			begin
				state_d.res.valid = 1'h1;
				state_d.res.hit = state_q.found;
				state_d.res.addr = state_q.found ? {4'h0, state_q.start} :
					def_addr; // [R15]
				state_d.res.act_size = unp_size;
				state_d.res.action = unp_action; // [R14]
				state_d.ready = 1'h1;
				state_d.st = CTL_IDLE;
			end
			default:
				state_d = CTL_STATE_RST;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			state_q <= CTL_STATE_RST;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (cfg_valid_in && cfg_in.addr < CTL_BLOCK_END)
		begin
			ent_mem[cfg_in.addr[11:0]] <= cfg_in.entry;
			msk_mem[cfg_in.addr[11:0]] <= cfg_in.mask;
			act_mem[cfg_in.addr[11:0]] <= cfg_in.action;
		end
		if (cfg_valid_in && cfg_slot[11])
			def_mem[cfg_slot[10:2]][cfg_slot[1:0]] <= cfg_in.action;
	end

	// Hit update sits after the write so a same-cycle set is not lost
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			en_q <= '0;
			cnt_q <= '0;
			def_cnt_q <= '0;
		end
		else
		begin
			if (cfg_valid_in && cfg_in.addr < CTL_BLOCK_END)
			begin
				en_q[cfg_in.addr[11:0]] <= cfg_in.enable;
				cnt_q[cfg_in.addr[11:0]] <= cfg_in.count;
			end
			if (cfg_valid_in && cfg_slot[11] && cfg_slot[1:0] == 2'h0)
				def_cnt_q[cfg_slot[10:2]] <= cfg_in.count;
			if (state_q.st == CTL_FETCH && state_q.found)
				cnt_q[state_q.start] <= 1'h1; // [R22]
			else if (state_q.st == CTL_FETCH)
				def_cnt_q[fetch_slot[10:2]] <= 1'h1; // [R22]
		end
	end

	// Cycles since the key was taken
	always_ff @(posedge ref_clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
			busy_q <= 13'h0;
		else if (state_q.ready)
			busy_q <= 13'h0;
		else
			busy_q <= busy_q + 13'h1;
	end

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!reset_n_in);

	sequence s_take;
		key_valid_in && key_ready_out;
	endsequence

	sequence s_fetch_default;
		state_q.st == CTL_FETCH && !state_q.found;
	endsequence

	a_take_starts_work: assert property ( // [R15]
		s_take |=> !key_ready_out && state_q.st != CTL_IDLE)
		else $error("key taken but lookup did not start");

	a_lookup_bounded: assert property (busy_q <= CTL_BUSY_MAX) // [R15]
		else $error("lookup ran past one full block scan");

	a_no_block_default: assert property ( // [R16]
		s_fetch_default ##0 !state_q.blk |=> res_out.valid && !res_out.hit)
		else $error("entry match reported with no block assigned");

	a_default_first: assert property ( // [R17]
		s_fetch_default ##0 state_q.req.lookup == 2'h0 |=>
		res_out.addr == 16'h8000 + {5'h00, $past(state_q.req.def_idx), 4'h0})
		else $error("first lookup default address wrong");

	a_default_second: assert property ( // [R18]
		s_fetch_default ##0 state_q.req.lookup == 2'h1 |=>
		res_out.addr == 16'h8720 + {5'h00, $past(state_q.req.def_idx), 4'h0})
		else $error("second lookup default address wrong");

	a_default_third: assert property ( // [R19]
		s_fetch_default ##0 state_q.req.lookup[1] |=>
		res_out.addr == 16'h8E40 + {5'h00, $past(state_q.req.def_idx), 4'h0})
		else $error("third lookup default address wrong");

	a_hit_counter_set: assert property ( // [R22]
		res_out.valid && res_out.hit |-> cnt_q[res_out.addr[11:0]])
		else $error("counter at matched rule offset 0 not set");

	a_hit_aligned_block: assert property ( // [R1]
		res_out.valid && res_out.hit |-> res_out.addr < CTL_BLOCK_END &&
		(res_out.addr[3:0] & (4'hF >> (3'h4 - $past(state_q.req.size, 2)))) == 4'h0)
		else $error("hit address outside block or misaligned");

	a_key_typegroup: assert property ( // [R24]
		state_q.st == CTL_SCAN && state_q.off == 4'h0 |->
		(scan_word & ((36'h2 << state_q.req.size) - 36'h1)) ==
		(36'h1 << state_q.req.size))
		else $error("key offset 0 type-group code wrong");

	a_action_x1_width: assert property ( // [R14]
		res_out.valid && res_out.act_size == CTL_ASZ_X1 |->
		res_out.action[272:69] == '0)
		else $error("single-address action wider than 69 bits");

endmodule

// ==== ctl_lookup_test.sv ====
`timescale 1ns/1ps
module ctl_lookup_test;
	import ctl_pkg::*;
	typedef struct packed {
		logic hit;
		logic [15:0] addr;
		logic chk_act;
		logic [1:0] asz;
		logic [CTL_ACT_LOG_W-1:0] act;
	} ctl_note_t;
	logic ref_clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic blocks_assigned_in = 1'b0;
	logic cfg_valid_in = 1'b0;
	ctl_cfg_t cfg_in = '0;
	logic key_valid_in = 1'b0;
	ctl_key_t key_in = '0;
	logic key_ready_out;
	ctl_res_t res_out;
	int fails = 0;
	int comparisons = 0;
	ctl_note_t notes[$];
	ctl_note_t seen_note;
	ctl_lookup ctl_lookup_i (
		.ref_clk_in(ref_clk_in),
		.reset_n_in(reset_n_in),
		.blocks_assigned_in(blocks_assigned_in),
		.cfg_valid_in(cfg_valid_in),
		.cfg_in(cfg_in),
		.key_valid_in(key_valid_in),
		.key_in(key_in),
		.key_ready_out(key_ready_out),
		.res_out(res_out)
	);
	initial forever #2 ref_clk_in = ~ref_clk_in;

	task automatic chk(input logic [CTL_ACT_LOG_W-1:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD at %0t: got %0h expected %0h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Counts: %0d compared, %0d bad", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic bad_wait();
		fails++;
		$display("BAD at %0t: wait ran out", $time);
		report_and_stop();
	endtask

	function automatic logic [CTL_KEY_W-1:0] rnd();
		logic [CTL_KEY_W-1:0] v;
		v = '0;
		for (int i = 0; i < 18; i++)
			v = {v[CTL_KEY_W-33:0], $urandom()};
		return v;
	endfunction

	function automatic ctl_note_t dflt(input logic [1:0] lk, logic [6:0] i);
		logic [15:0] b;
		b = (lk == 2'h0) ? 16'h8000 : (lk == 2'h1) ? 16'h8720 : 16'h8E40;
		if (i > 7'h71)
			i = 7'h71;
		return '{hit: 1'b0, addr: b + 16'({i, 4'h0}), default: '0};
	endfunction

	// Held valid between writes so back-to-back writes never toggle it
	task automatic cfg_w(input logic [15:0] a, input logic en,
		input logic [35:0] e, input logic [69:0] act);
		@(negedge ref_clk_in);
		cfg_valid_in = 1'b1;
		cfg_in = '{addr: a, enable: en, entry: e, mask: '0, action: act,
			count: 1'b0};
		@(posedge ref_clk_in);
	endtask

	task automatic cfg_end();
		@(negedge ref_clk_in);
		cfg_valid_in = 1'b0;
	endtask

	task automatic put_rule(input logic [15:0] base, input int sz, asz,
		input logic [CTL_KEY_W-1:0] k, input logic [CTL_ACT_LOG_W-1:0] a,
		output logic [CTL_ACT_LOG_W-1:0] exp);
		logic [15:0][35:0] ew;
		logic [15:0][69:0] aw;
		logic [15:0] en;
		int ep;
		int ap;
		int w;
		int n;
		ep = 0;
		ap = 0;
		ew = '0;
		aw = '0;
		en = '0;
		n = 1 << ((sz > asz) ? sz : asz);
		for (int o = 0; o < n; o++)
		begin
			w = (o == 0) ? sz + 1 : (o % 2) ? 1 : (o % 4 == 2) ? 2 :
				(o % 8 == 4) ? 3 : 4;
			en[o] = o < (1 << sz);
			ew[o] = 36'((k >> ep) << w) |
				36'((o == 0) ? (1 << sz) : 0);
			if (en[o])
				ep += 36 - w;
			if (o < (1 << asz))
			begin
				w = (o == 0) ? asz + 1 : (o % 2) ? 1 : 2;
				aw[o] = 70'((a >> ap) << w) | 70'((o == 0) ? (1 << asz) : 0);
				ap += 70 - w;
			end
		end
		exp = a & ~({CTL_ACT_LOG_W{1'b1}} << ap);
		for (int o = n - 1; o >= 0; o--)
			cfg_w(base + 16'(o), en[o], ew[o], aw[o]);
		cfg_end();
	endtask

	task automatic send_key(input logic [1:0] lk, input logic [2:0] sz,
		input logic [6:0] idx, input logic [CTL_KEY_W-1:0] k,
		input ctl_note_t n);
		int t;
		@(negedge ref_clk_in);
		key_valid_in = 1'b1;
		key_in = '{lookup: lk, size: sz, def_idx: idx, key: k};
		notes.push_back(n);
		t = 0;
		while (key_ready_out !== 1'b1)
		begin
			t++;
			if (t > 5000)
				bad_wait();
			@(negedge ref_clk_in);
		end
		@(negedge ref_clk_in);
		key_valid_in = 1'b0;
	endtask

	// Results are seen at the falling edge, mid-way through their cycle
	always @(negedge ref_clk_in)
	if (res_out.valid === 1'b1)
	begin
		if (notes.size() == 0)
			chk(1'b1, 1'b0);
		else
		begin
			seen_note = notes.pop_front();
			chk(res_out.hit, seen_note.hit);
			chk(res_out.addr, seen_note.addr);
			if (seen_note.chk_act)
			begin
				chk(res_out.act_size, seen_note.asz);
				chk(res_out.action, seen_note.act);
			end
		end
	end

	initial
	begin
		logic [CTL_KEY_W-1:0] k[4];
		logic [CTL_ACT_LOG_W-1:0] a[4];
		logic [CTL_ACT_LOG_W-1:0] e[4];
		logic [6:0] idx;
		int t;
		void'($urandom(32'h3226));
		repeat (20) @(negedge ref_clk_in);
		chk(key_ready_out, 1'b1);
		chk(res_out.valid, 1'b0);
		chk(res_out.addr, 16'h0000);
		chk(res_out.action, '0);
		reset_n_in = 1'b1;
		$display("Test reset done");
		for (int i = 0; i < 8; i++)
		begin
			idx = (i == 6) ? 7'h71 : (i == 7) ? 7'h7F : 7'($urandom_range(113));
			send_key(2'(i % 4), 3'(i % 5), idx, rnd(), dflt(2'(i % 4), idx));
		end
		$display("Test no block done");
		for (int i = 0; i < 4; i++)
		begin
			k[i] = rnd();
			a[i] = CTL_ACT_LOG_W'(rnd());
		end
		put_rule(16'h0005, 0, 0, k[0], a[0], e[0]);
		put_rule(16'h000C, 2, 2, k[1], a[1], e[1]);
		put_rule(16'h0020, 4, 0, k[2], a[2], e[2]);
		put_rule(16'h0040, 1, 2, k[3], a[3], e[3]);
		send_key(2'h0, 3'h0, 7'h05, k[0], dflt(2'h0, 7'h05));
		@(negedge ref_clk_in);
		blocks_assigned_in = 1'b1;
		send_key(2'h0, 3'h0, 7'h01, k[0], '{1'b1, 16'h0005, 1'b1, 2'h0, e[0]});
		send_key(2'h1, 3'h2, 7'h02, k[1], '{1'b1, 16'h000C, 1'b1, 2'h2, e[1]});
		send_key(2'h2, 3'h4, 7'h03, k[2], '{1'b1, 16'h0020, 1'b1, 2'h0, e[2]});
		send_key(2'h3, 3'h1, 7'h04, k[3], '{1'b1, 16'h0040, 1'b1, 2'h2, e[3]});
		send_key(2'h2, 3'h2, 7'h09, k[2], dflt(2'h2, 7'h09));
		$display("Test programmed rules done");
		cfg_w(16'h8790, 1'b1, '0, {a[0][68:0], 1'b1});
		cfg_end();
		send_key(2'h1, 3'h3, 7'h07, rnd(),
			'{1'b0, 16'h8790, 1'b1, 2'h0, {204'h0, a[0][68:0]}});
		t = 0;
		while (notes.size() != 0)
		begin
			t++;
			if (t > 5000)
				bad_wait();
			@(negedge ref_clk_in);
		end
		$display("Test default action done");
		report_and_stop();
	end
endmodule

// ==== ctl_pkg.sv ====
package ctl_pkg;

	// Memory geometry
	localparam int CTL_ENTRY_W = 36;
	localparam int CTL_ACTION_W = 70;
	localparam int CTL_BLOCK_ADDRS = 4096;
	localparam int CTL_KEY_W = 545;
	localparam int CTL_ACT_LOG_W = 273;
	localparam int CTL_DEF_RULES = 114;
	localparam int CTL_DEF_TOTAL = 342;
	localparam int CTL_DEF_WORDS = 4;

	// Address map
	localparam logic [15:0] CTL_BLOCK_END = 16'h1000;
	localparam logic [15:0] CTL_DEF_BASE_FIRST = 16'h8000;
	localparam logic [15:0] CTL_DEF_BASE_SECOND = 16'h8720;
	localparam logic [15:0] CTL_DEF_BASE_THIRD = 16'h8E40;
	localparam logic [8:0] CTL_DEF_SLOTS = 9'h156;
	localparam logic [6:0] CTL_DEF_LAST = 7'h71;
	localparam logic [12:0] CTL_SCAN_END = 13'h1000;
	localparam logic [12:0] CTL_BUSY_MAX = 13'h1004;

	// Entry size codes, log2 of the address count
	localparam logic [2:0] CTL_SIZE_X1 = 3'h0;
	localparam logic [2:0] CTL_SIZE_MAX = 3'h4;

	// Action sizes
	localparam logic [1:0] CTL_ASZ_X1 = 2'h0;
	localparam logic [1:0] CTL_ASZ_X2 = 2'h1;
	localparam logic [1:0] CTL_ASZ_X4 = 2'h2;

	typedef enum logic [1:0] {CTL_IDLE, CTL_SCAN, CTL_FETCH} ctl_st_t;

	typedef struct packed {
		logic [15:0] addr;
		logic enable;
		logic [CTL_ENTRY_W-1:0] entry;
		logic [CTL_ENTRY_W-1:0] mask;
		logic [CTL_ACTION_W-1:0] action;
		logic count;
	} ctl_cfg_t;

	typedef struct packed {
		logic [1:0] lookup;
		logic [2:0] size;
		logic [6:0] def_idx;
		logic [CTL_KEY_W-1:0] key;
	} ctl_key_t;

	typedef struct packed {
		logic valid;
		logic hit;
		logic [15:0] addr;
		logic [1:0] act_size;
		logic [CTL_ACT_LOG_W-1:0] action;
	} ctl_res_t;

	typedef struct packed {
		ctl_st_t st;
		logic ready;
		logic blk;
		logic found;
		logic [12:0] addr;
		logic [11:0] start;
		logic [3:0] off;
		logic [CTL_KEY_W-1:0] key_sh;
		ctl_key_t req;
		ctl_res_t res;
	} ctl_state_t;

	localparam ctl_state_t CTL_STATE_RST = '{st: CTL_IDLE, ready: 1'h1,
		default: '0};

endpackage
